// *** iem_top.sv ***
`timescale 1ns/1ps
module iem_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST_B,
  // APB slave.
  input  wire logic [ADDR_W-1:0]         PADDR,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  // Event sources from the link master.
  input  wire iem_pkg::iem_local_evt_t   LOCAL_EVT,
  input  wire logic [7:0]                REMOTE_SUMMARY,
  input  wire logic [iem_pkg::QUAL_W-1:0] LINK_QUALITY,
  // Results.
  output logic                           REMOTE_EVENT_FLAG,
  output logic                           LINK_QUALITY_LOW_WARNING,
  output logic                           IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic        acc_setup;
  logic        acc_done;
  logic        hit_h;
  logic        hit_l;
  logic        hit_s;
  logic        hit_st;
  logic        hit_any;
  logic        wr_h;
  logic        wr_l;
  logic        wr_s;
  logic [7:0]  addr8;

  // The low address bits select the register; higher bits must be zero.
  assign addr8     = 8'(PADDR);
  assign acc_setup = PSEL && !PENABLE;
  assign acc_done  = PSEL && PENABLE;
  assign hit_h     = addr8 == iem_pkg::reg_addr(iem_pkg::IDX_MASK_H);
  assign hit_l     = addr8 == iem_pkg::reg_addr(iem_pkg::IDX_MASK_L);
  assign hit_s     = addr8 == iem_pkg::reg_addr(iem_pkg::IDX_MASK_S);
  assign hit_st    = addr8 == iem_pkg::reg_addr(iem_pkg::IDX_STATUS);
  assign hit_any   = (hit_h || hit_l || hit_s || hit_st) && (PADDR >> 8) == 0;

  // Writes take effect at the edge that completes the access phase.
  assign wr_h = acc_done && PWRITE && hit_any && hit_h;
  assign wr_l = acc_done && PWRITE && hit_any && hit_l;
  assign wr_s = acc_done && PWRITE && hit_any && hit_s;

  ////////////////////////////////////////////////////////////////////////
  // Mask registers.

  logic [7:0] mask_h_q;
  logic [7:0] mask_l_q;
  logic [7:0] mask_s_q;

  // High byte mask; the remote bit is not stored here.
  iem_mask_reg #(
    .RST  (iem_pkg::RST_MASK),
    .IMPL (iem_pkg::IMPL_MASK_H)
  ) u_mask_h (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .wr_en   (wr_h),
    .wr_data (PWDATA[7:0]),
    .q       (mask_h_q)
  );

  // Low byte mask.
  iem_mask_reg #(
    .RST  (iem_pkg::RST_MASK),
    .IMPL (iem_pkg::IMPL_MASK_L)
  ) u_mask_l (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .wr_en   (wr_l),
    .wr_data (PWDATA[7:0]),
    .q       (mask_l_q)
  );

  // Remote summary mask, write only.
  iem_mask_reg #(
    .RST  (iem_pkg::RST_MASK),
    .IMPL (iem_pkg::IMPL_MASK_S)
  ) u_mask_s (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .wr_en   (wr_s),
    .wr_data (PWDATA[7:0]),
    .q       (mask_s_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event flags and masking.

  logic        remote_event_enable;
  logic        remote_flag;
  logic        quality_low;
  logic [7:0]  mask_h_eff;
  logic [7:0]  flag_h;
  logic [7:0]  flag_l;
  logic [15:0] flag_vec;
  logic [15:0] mask_vec;
  logic        irq_d;
  logic        irq_q;
  logic        rflag_q;
  logic        qlow_q;

  // The remote mask bit is derived from the summary mask itself.
  assign remote_event_enable = |mask_s_q;
  assign remote_flag = |(REMOTE_SUMMARY & mask_s_q);
  assign quality_low = LINK_QUALITY < iem_pkg::QUAL_LOW_LIMIT;

  // Effective high mask with the derived remote bit merged in.
  always_comb begin
    mask_h_eff = mask_h_q;
    mask_h_eff[iem_pkg::BIT_REM] = remote_event_enable;
  end

  // Place each source at its mask position; unused positions stay zero.
  always_comb begin
    flag_h = 8'h00;
    flag_l = 8'h00;
    flag_h[iem_pkg::BIT_PRST] = LOCAL_EVT.prst;
    flag_h[iem_pkg::BIT_DTE]  = LOCAL_EVT.dte;
    flag_h[iem_pkg::BIT_VPOS] = LOCAL_EVT.vpos;
    flag_h[iem_pkg::BIT_POS]  = LOCAL_EVT.pos;
    flag_h[iem_pkg::BIT_SCE]  = LOCAL_EVT.sce;
    flag_h[iem_pkg::BIT_REM]  = remote_flag;
    flag_l[iem_pkg::BIT_MIN]  = LOCAL_EVT.min;
    flag_l[iem_pkg::BIT_ANS]  = LOCAL_EVT.ans;
    flag_l[iem_pkg::BIT_QLOW] = quality_low;
    flag_l[iem_pkg::BIT_FREL] = LOCAL_EVT.frel;
    flag_l[iem_pkg::BIT_FRES] = LOCAL_EVT.fres;
  end

  // All enabled sources meet in one OR; the line drops when none is left.
  assign flag_vec = {flag_h, flag_l};
  assign mask_vec = {mask_h_eff, mask_l_q};
  assign irq_d    = |(flag_vec & mask_vec);

  // Registered outputs keep glitches of the event logic off the pins.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      irq_q   <= 1'b0;
      rflag_q <= 1'b0;
      qlow_q  <= 1'b0;
    end else begin
      irq_q   <= irq_d;
      rflag_q <= remote_flag;
      qlow_q  <= quality_low;
    end
  end

  assign IRQ                      = irq_q;
  assign REMOTE_EVENT_FLAG        = rflag_q;
  assign LINK_QUALITY_LOW_WARNING = qlow_q;

  ////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Status shows the raw flags and the registered IRQ and remote flag.
  assign status_word = {14'h0000, rflag_q, irq_q, flag_vec};

  // Summary mask is write only and reads as zero.
  assign rd_mux = !hit_any ? 32'h0000_0000 :
                  hit_h    ? {24'h00_0000, mask_h_eff} :
                  hit_l    ? {24'h00_0000, mask_l_q} :
                  hit_st   ? status_word : 32'h0000_0000;

  // Read data is captured in the setup phase and held for the access phase.
  assign prdata_d = (acc_setup && !PWRITE) ? rd_mux : prdata_q;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // No wait states; unmapped addresses answer with an error.
  assign PRDATA  = prdata_q;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc_done && !hit_any;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  // A completed write to one of the mask registers.
  sequence s_wr_h;
    PSEL && PENABLE && PWRITE && hit_any && hit_h;
  endsequence

  sequence s_wr_s;
    PSEL && PENABLE && PWRITE && hit_any && hit_s;
  endsequence

  // A read of the high mask from setup to access.
  sequence s_rd_h;
    PSEL && !PENABLE && !PWRITE && hit_any && hit_h ##1 PSEL && PENABLE;
  endsequence

  a_prst_irq: assert property (
    LOCAL_EVT.prst && mask_h_q[iem_pkg::BIT_PRST] |=> IRQ)
    else $error("Masked protocol reset did not raise the interrupt.");

  a_dte_irq: assert property (
    LOCAL_EVT.dte && mask_h_q[iem_pkg::BIT_DTE] |=> IRQ)
    else $error("Masked deviation error did not raise the interrupt.");

  a_vpos_irq: assert property (
    LOCAL_EVT.vpos && mask_h_q[iem_pkg::BIT_VPOS] |=> IRQ)
    else $error("Masked safe position error did not raise the interrupt.");

  a_pos_irq: assert property (
    LOCAL_EVT.pos && mask_h_q[iem_pkg::BIT_POS] |=> IRQ)
    else $error("Masked fast position error did not raise the interrupt.");

  a_sce_irq: assert property (
    LOCAL_EVT.sce && mask_h_q[iem_pkg::BIT_SCE] |=> IRQ)
    else $error("Masked safe channel error did not raise the interrupt.");

  a_remote_irq: assert property (
    |(REMOTE_SUMMARY & mask_s_q) |=> IRQ && REMOTE_EVENT_FLAG)
    else $error("Enabled remote event did not raise the interrupt.");

  a_reserved_zero: assert property (
    s_rd_h |-> (PRDATA[7] == 1'b0) && (PRDATA[4] == 1'b0))
    else $error("Unimplemented high mask bit read as one.");

  a_reserved_low: assert property (
    (mask_l_q & ~iem_pkg::IMPL_MASK_L) == 8'h00)
    else $error("Unimplemented low mask bit holds a one.");

  a_min_irq: assert property (
    LOCAL_EVT.min && mask_l_q[iem_pkg::BIT_MIN] |=> IRQ)
    else $error("Masked init acknowledgment did not raise the interrupt.");

  a_ans_irq: assert property (
    LOCAL_EVT.ans && mask_l_q[iem_pkg::BIT_ANS] |=> IRQ)
    else $error("Masked long answer error did not raise the interrupt.");

  a_qlow_irq: assert property (
    LINK_QUALITY < iem_pkg::QUAL_LOW_LIMIT && mask_l_q[iem_pkg::BIT_QLOW] |=> IRQ)
    else $error("Masked quality warning did not raise the interrupt.");

  a_frel_irq: assert property (
    LOCAL_EVT.frel && mask_l_q[iem_pkg::BIT_FREL] |=> IRQ)
    else $error("Masked long channel free did not raise the interrupt.");

  a_fres_irq: assert property (
    LOCAL_EVT.fres && mask_l_q[iem_pkg::BIT_FRES] |=> IRQ)
    else $error("Masked short channel free did not raise the interrupt.");

  a_summary_gate: assert property (
    (REMOTE_SUMMARY & mask_s_q) == 8'h00 |=> !REMOTE_EVENT_FLAG)
    else $error("Remote flag set with no enabled summary bit.");

  a_remote_flag: assert property (
    REMOTE_EVENT_FLAG == $past(|(REMOTE_SUMMARY & mask_s_q)))
    else $error("Remote flag differs from the masked summary OR.");

  a_rem_readback: assert property (
    s_rd_h |-> PRDATA[iem_pkg::BIT_REM] == |$past(mask_s_q))
    else $error("Remote mask bit does not follow the summary mask.");

  a_sum_write: assert property (
    s_wr_s |=> mask_s_q == $past(PWDATA[7:0]))
    else $error("Summary mask write not stored.");

  a_combine: assert property (
    (LOCAL_EVT.prst && mask_h_q[iem_pkg::BIT_PRST] && LOCAL_EVT.fres
     && mask_l_q[iem_pkg::BIT_FRES]) ##1 !LOCAL_EVT.prst && LOCAL_EVT.fres
     && mask_l_q[iem_pkg::BIT_FRES] |=> IRQ [*1])
    else $error("Remaining enabled source did not hold the interrupt.");

  a_mask_write: assert property (
    s_wr_h |=> mask_h_q == ($past(PWDATA[7:0]) & iem_pkg::IMPL_MASK_H))
    else $error("High mask write not stored.");

  a_quality_out: assert property (
    LINK_QUALITY >= iem_pkg::QUAL_LOW_LIMIT |=> !LINK_QUALITY_LOW_WARNING)
    else $error("Quality warning set at or above the limit.");

  a_irq_clear: assert property (
    ((flag_vec & mask_vec) == 16'h0000) [*2] |-> !IRQ ##1 !IRQ)
    else $error("Interrupt held with no enabled flag.");

  a_reset_quiet: assert property (
    $rose(RST_B) |-> mask_h_q == iem_pkg::RST_MASK && mask_l_q == iem_pkg::RST_MASK
                     && mask_s_q == iem_pkg::RST_MASK)
    else $error("Mask registers not cleared by reset.");

endmodule

// *** iem_pkg.sv ***
// Notes on behaviour
// - Protocol reset event interrupts when its mask set.
// - Estimator deviation error interrupts when masked in.
// - Safe position error interrupts when masked in.
// - Fast position error interrupts when masked in.
// - Safe channel error interrupts when masked in.
// - Enabled remote events interrupt when remote mask set.
// - Unimplemented mask bits read zero, except high bit 6, which reads OR of summary mask.
// - Message init acknowledgment interrupts when masked in.
// - Long answer error interrupts when masked in.
// - Low link quality warning interrupts when masked in.
// - Long message channel free interrupts when masked.
// - Short message channel free interrupts when masked.
// - Summary mask gates remote flag and interrupt.
// - Remote event flag is OR of enabled summary bits.
// - Remote mask bit reads OR of summary mask.
// - Many enabled sources combine onto one interrupt.
// - High and low masks select local event flags.
// - Quality warning set while quality below fourteen.
package iem_pkg;

  // Register indices; the bus address is four times the index.
  localparam logic [7:0] IDX_MASK_H = 8'h06;
  localparam logic [7:0] IDX_MASK_L = 8'h07;
  localparam logic [7:0] IDX_MASK_S = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h10;

  // Reset values and implemented bits of the mask registers.
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] IMPL_MASK_H = 8'h2f;
  localparam logic [7:0] IMPL_MASK_L = 8'h37;
  localparam logic [7:0] IMPL_MASK_S = 8'hff;

  // Bit positions in the high event byte.
  localparam int BIT_PRST = 0;
  localparam int BIT_DTE  = 1;
  localparam int BIT_VPOS = 2;
  localparam int BIT_POS  = 3;
  localparam int BIT_SCE  = 5;
  localparam int BIT_REM  = 6;

  // Bit positions in the low event byte.
  localparam int BIT_FRES = 0;
  localparam int BIT_FREL = 1;
  localparam int BIT_QLOW = 2;
  localparam int BIT_ANS  = 4;
  localparam int BIT_MIN  = 5;

  // Status register field positions.
  localparam int ST_IRQ = 16;
  localparam int ST_REM = 17;

  // Link quality threshold for the low warning.
  localparam int QUAL_W = 4;
  localparam logic [QUAL_W-1:0] QUAL_LOW_LIMIT = 4'he;

  // Local event flags from the link master, same clock.
  typedef struct packed {
    logic prst;
    logic dte;
    logic vpos;
    logic pos;
    logic sce;
    logic min;
    logic ans;
    logic frel;
    logic fres;
  } iem_local_evt_t;

  // Byte address of a register index.
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

// *** iem_mask_reg.sv ***
`timescale 1ns/1ps
module iem_mask_reg #(
  parameter logic [7:0] RST  = 8'h00,
  parameter logic [7:0] IMPL = 8'hff
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Write port.
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored mask.
  output logic      [7:0] q
);

  logic [7:0] mask_q;
  logic [7:0] mask_d;

  // Bits that are not implemented never store a one.
  assign mask_d = wr_en ? (wr_data & IMPL) : mask_q;

  // Mask storage, cleared by reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign q = mask_q;

endmodule

// *** iem_host_model.sv ***
`timescale 1ns/1ps
module iem_host_model (
  // Clock.
  input  wire logic        clk,
  // APB master side.
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Interrupt line from the block.
  input  wire logic        irq
);
  logic hung;
  int   irq_rises;
  logic irq_q;

  // The bus is idle at time zero.
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
    irq_rises = 0;
    irq_q = 1'b0;
  end

  // Counts rising edges of the interrupt line as the host sees them.
  always @(posedge clk) begin
    if (irq === 1'b1 && irq_q !== 1'b1)
      irq_rises <= irq_rises + 1;
    irq_q <= irq;
  end

  // One transfer; data and error are taken at the ready edge, then the bus is let go.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
      hung = 1'b1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] mh, ml, ms;
    logic [8:0] ev;
    logic [7:0] sm;
    logic [3:0] q;
    logic       irq, rem;
  } iem_row_t;
  localparam int NR = 29;
  iem_row_t rows [NR] = '{
    '{8'h01,8'h00,8'h00,9'h100,8'h00,4'hf,1'b1,1'b0}, '{8'hfe,8'hff,8'h00,9'h100,8'h00,4'hf,1'b0,1'b0},
    '{8'h02,8'h00,8'h00,9'h080,8'h00,4'hf,1'b1,1'b0}, '{8'hfd,8'hff,8'h00,9'h080,8'h00,4'hf,1'b0,1'b0},
    '{8'h04,8'h00,8'h00,9'h040,8'h00,4'hf,1'b1,1'b0}, '{8'hfb,8'hff,8'h00,9'h040,8'h00,4'hf,1'b0,1'b0},
    '{8'h08,8'h00,8'h00,9'h020,8'h00,4'hf,1'b1,1'b0}, '{8'hf7,8'hff,8'h00,9'h020,8'h00,4'hf,1'b0,1'b0},
    '{8'h20,8'h00,8'h00,9'h010,8'h00,4'hf,1'b1,1'b0}, '{8'hdf,8'hff,8'h00,9'h010,8'h00,4'hf,1'b0,1'b0},
    '{8'h00,8'h20,8'h00,9'h008,8'h00,4'hf,1'b1,1'b0}, '{8'hff,8'hdf,8'h00,9'h008,8'h00,4'hf,1'b0,1'b0},
    '{8'h00,8'h10,8'h00,9'h004,8'h00,4'hf,1'b1,1'b0}, '{8'hff,8'hef,8'h00,9'h004,8'h00,4'hf,1'b0,1'b0},
    '{8'h00,8'h02,8'h00,9'h002,8'h00,4'hf,1'b1,1'b0}, '{8'hff,8'hfd,8'h00,9'h002,8'h00,4'hf,1'b0,1'b0},
    '{8'h00,8'h01,8'h00,9'h001,8'h00,4'hf,1'b1,1'b0}, '{8'hff,8'hfe,8'h00,9'h001,8'h00,4'hf,1'b0,1'b0},
    '{8'h00,8'h04,8'h00,9'h000,8'h00,4'hd,1'b1,1'b0}, '{8'hff,8'hfb,8'h00,9'h000,8'h00,4'hd,1'b0,1'b0},
    '{8'h00,8'h04,8'h00,9'h000,8'h00,4'he,1'b0,1'b0}, '{8'h00,8'h04,8'h00,9'h000,8'h00,4'h0,1'b1,1'b0},
    '{8'h00,8'h00,8'h01,9'h000,8'h01,4'hf,1'b1,1'b1}, '{8'hff,8'hff,8'hfe,9'h000,8'h01,4'hf,1'b0,1'b0},
    '{8'h00,8'h00,8'h80,9'h000,8'h80,4'hf,1'b1,1'b1}, '{8'h00,8'h00,8'h00,9'h000,8'hff,4'hf,1'b0,1'b0},
    '{8'h00,8'h00,8'h24,9'h000,8'h04,4'hf,1'b1,1'b1}, '{8'h2f,8'h37,8'hff,9'h1ff,8'hff,4'h0,1'b1,1'b1},
    '{8'h00,8'h00,8'h00,9'h1ff,8'hff,4'h0,1'b0,1'b0}};

  logic                    clk_sys;
  logic                    rst_b;
  logic [7:0]              paddr;
  logic                    psel, penable, pwrite, pready, pslverr;
  logic [31:0]             pwdata, prdata, rdat;
  iem_pkg::iem_local_evt_t evt;
  logic [7:0]              summ;
  logic [3:0]              qual;
  logic                    rem_flag, qlw, irq, rerr;
  int                      err_count, n_tests, r0;

  ////////////////////////////////////////////////////////////////////////////////
  // Block under test and the host on its far side.
  iem_top #(.ADDR_W(8)) i_iem_top (.CLK_SYS(clk_sys), .RST_B(rst_b), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LOCAL_EVT(evt), .REMOTE_SUMMARY(summ), .LINK_QUALITY(qual),
    .REMOTE_EVENT_FLAG(rem_flag), .LINK_QUALITY_LOW_WARNING(qlw), .IRQ(irq));
  iem_host_model i_iem_host_model (.clk(clk_sys), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // Free-running 50 MHz clock.
  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus transfer; a hung bus counts as a mismatch and ends the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_iem_host_model.xfer(w, a, d, rdat, rerr);
    if (i_iem_host_model.hung === 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask

  // Lets the registered outputs follow their inputs.
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    evt = '0;
    summ = 8'h00;
    qual = 4'hf;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk("irq at reset", 32'h0, {31'h0, irq});
    bus(1'b0, 8'h18, 32'h0);
    chk("mask high at reset", 32'h0, rdat);
    chk("slave error mapped", 32'h0, {31'h0, rerr});
    bus(1'b0, 8'h1c, 32'h0);
    chk("mask low at reset", 32'h0, rdat);
    $display("test reset done");
    for (r0 = 0; r0 < NR; r0++) begin
      @(posedge clk_sys);
      evt <= rows[r0].ev;
      summ <= rows[r0].sm;
      qual <= rows[r0].q;
      bus(1'b1, 8'h18, {24'h0, rows[r0].mh});
      bus(1'b1, 8'h1c, {24'h0, rows[r0].ml});
      bus(1'b1, 8'h20, {24'h0, rows[r0].ms});
      settle();
      chk("irq", {31'h0, rows[r0].irq}, {31'h0, irq});
      chk("remote flag", {31'h0, rows[r0].rem}, {31'h0, rem_flag});
      chk("quality warning", {31'h0, rows[r0].q < 4'he}, {31'h0, qlw});
      bus(1'b0, 8'h18, 32'h0);
      chk("mask high", {24'h0, (rows[r0].mh & 8'h2f) | {1'b0, |rows[r0].ms, 6'h0}}, rdat);
      bus(1'b0, 8'h1c, 32'h0);
      chk("mask low", {24'h0, rows[r0].ml & 8'h37}, rdat);
    end
    $display("test table done");
    @(posedge clk_sys);
    evt <= '0;
    summ <= 8'h00;
    bus(1'b1, 8'h1c, 32'h1);
    bus(1'b1, 8'h18, 32'h1);
    r0 = i_iem_host_model.irq_rises;
    @(posedge clk_sys);
    evt <= 9'h101;
    settle();
    chk("irq raised", 32'h1, {31'h0, irq});
    chk("irq rises", r0 + 1, i_iem_host_model.irq_rises);
    bus(1'b0, 8'h40, 32'h0);
    chk("status", 32'h0001_0105, rdat);
    @(posedge clk_sys);
    evt <= 9'h001;
    settle();
    chk("irq held", 32'h1, {31'h0, irq});
    @(posedge clk_sys);
    evt <= 9'h000;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq dropped", 32'h0, {31'h0, irq});
    $display("test deassert done");
    bus(1'b1, 8'h24, 32'hff);
    chk("slave error", 32'h1, {31'h0, rerr});
    bus(1'b0, 8'h24, 32'h0);
    chk("unmapped data", 32'h0, rdat);
    bus(1'b1, 8'h20, 32'h5a);
    bus(1'b0, 8'h20, 32'h0);
    chk("summary mask read", 32'h0, rdat);
    bus(1'b0, 8'h18, 32'h0);
    chk("mask high kept", 32'h41, rdat);
    $display("test unmapped done");
    @(posedge clk_sys);
    evt <= 9'h100;
    settle();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq in reset", 32'h0, {31'h0, irq});
    @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b0, 8'h18, 32'h0);
    chk("mask high after reset", 32'h0, rdat);
    settle();
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("test midrun reset done");
    print_verdict();
  end
endmodule
